// [sim/ebracd_far_side_model.sv]
`timescale 1ns/1ns

// ==========================================================
// far side: slow memory on the bus and one outside master
module ebracd_far_side_model (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // bus as the memory sees it
    input wire logic [31:0] addr,
    input wire logic [15:0] data_out,
    input wire logic data_oe,
    input wire logic rd_n,
    input wire logic wr_n,
    output logic [15:0] data_in,
    output logic wait_n,
    output logic [15:0] last_wdata,
    // scenario knobs and arbitration
    input wire logic [3:0] wait_len,
    input wire logic want,
    input wire logic grant_n,
    output logic request_n
);
    logic [15:0] noise;
    logic [3:0] wait_left;

    // data only during the read strobe; otherwise it churns every cycle
    // so a sample taken at the wrong edge cannot match by luck
    assign data_in = !rd_n ? (addr[31:16] ^ addr[15:0] ^ 16'h3c5a) : noise;

    // a slow part holds wait low ahead of the strobe
    assign wait_n = (wait_left == 4'h0);

    // wait counting, write capture and the master's request line
    always_ff @(posedge clk) begin
        noise <= noise * 16'h6255 + 16'h3619;
        if (!wr_n && data_oe) begin
            last_wdata <= data_out;
        end
        if (rd_n && wr_n) begin
            wait_left <= wait_len;
        end else if (wait_left != 4'h0) begin
            wait_left <= wait_left - 4'h1;
        end
        if (reset) begin
            request_n <= 1'b1;
            noise <= 16'h0001;
        end else if (want) begin
            request_n <= 1'b0;
        end else if (!grant_n) begin
            request_n <= 1'b1; // held until granted
        end
    end
endmodule : ebracd_far_side_model

// [sim/tb_ebracd_ext_bus.sv]
`timescale 1ns/1ns

module tb_ebracd_ext_bus;
    import ebracd_pkg::*;

    // ==========================================================
    // signals
    logic REF_CLK, RESET, REQ_VALID, REQ_WRITE, REQ_LAST, RSP_DONE;
    logic [31:0] REQ_ADDR, ADDR_OUT, seed;
    logic [15:0] REQ_WDATA, RSP_RDATA, DATA_OUT, DATA_IN, last_wdata;
    ebracd_range_type [3:0] RANGE_BASE_MASK;
    logic [4:0][1:0] RECOVERY_CYCLES;
    logic ADDR_OE, DATA_OE, RD_N, WR_N, CTRL_OE, WAIT_N, REQUEST_N, GRANT_N;
    logic [3:0] cs_n, wait_len;
    logic want;
    int miscompares, n_tests, cyc, t;

    ebracd_ext_bus u_ebracd_ext_bus (
        .REF_CLK(REF_CLK), .RESET(RESET), .REQ_VALID(REQ_VALID),
        .REQ_ADDR(REQ_ADDR), .REQ_WRITE(REQ_WRITE), .REQ_LAST(REQ_LAST),
        .REQ_WDATA(REQ_WDATA), .RSP_DONE(RSP_DONE), .RSP_RDATA(RSP_RDATA),
        .RANGE_BASE_MASK(RANGE_BASE_MASK), .RECOVERY_CYCLES(RECOVERY_CYCLES),
        .ADDR_OUT(ADDR_OUT), .ADDR_OE(ADDR_OE), .DATA_OUT(DATA_OUT),
        .DATA_OE(DATA_OE), .DATA_IN(DATA_IN), .RD_N(RD_N), .WR_N(WR_N),
        .CTRL_OE(CTRL_OE), .WAIT_N(WAIT_N), .CHIP_SELECT_0_N(cs_n[0]),
        .CHIP_SELECT_1_N(cs_n[1]), .CHIP_SELECT_2_N(cs_n[2]),
        .CHIP_SELECT_3_N(cs_n[3]), .EXT_MASTER_REQUEST_N(REQUEST_N),
        .EXT_MASTER_GRANT_N(GRANT_N));

    ebracd_far_side_model u_ebracd_far_side_model (
        .clk(REF_CLK), .reset(RESET), .addr(ADDR_OUT), .data_out(DATA_OUT),
        .data_oe(DATA_OE), .rd_n(RD_N), .wr_n(WR_N), .data_in(DATA_IN),
        .wait_n(WAIT_N), .last_wdata(last_wdata), .wait_len(wait_len),
        .want(want), .grant_n(GRANT_N), .request_n(REQUEST_N));

    // ==========================================================
    // reference model
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    // lowest matching select wins; 4 means outside every range
    function automatic int exp_slot(logic [31:0] a);
        logic [31:0] care;
        for (int r = 0; r < 4; r++) begin
            care = (r < 2)
                ? ~({2'h0, RANGE_BASE_MASK[r].mask, 14'h0} | 32'h3fff)
                : ~({1'h0, RANGE_BASE_MASK[r].mask, 15'h0} | 32'h7fff);
            if (((a ^ {RANGE_BASE_MASK[r].base, 16'h0}) & care) == 0) begin
                return r;
            end
        end
        return 4;
    endfunction : exp_slot

    // spacing of done pulses for a held request, dummies only after reads
    function automatic int exp_gap(logic [31:0] a, logic wr);
        int n;
        n = int'(RECOVERY_CYCLES[exp_slot(a)]);
        if (wr) begin
            return 5;
        end
        return (n > 2) ? 7 : 5 + n;
    endfunction : exp_gap

    // ==========================================================
    // checking and closing
    task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    // ==========================================================
    // bus request tasks; inputs change only after the done cycle
    task automatic drive(logic [31:0] a, logic wr, logic last);
        @(posedge REF_CLK);
        REQ_VALID <= 1'b1;
        REQ_ADDR <= a;
        REQ_WRITE <= wr;
        REQ_LAST <= last;
        REQ_WDATA <= 16'(rnd() >> 7);
    endtask : drive

    task automatic wait_done(output int when);
        int n;
        n = 0;
        do begin
            @(negedge REF_CLK);
            n++;
        end while (RSP_DONE !== 1'b1 && n < 300);
        when = cyc;
        if (n >= 300) begin
            miscompares++;
            report_and_stop();
        end
    endtask : wait_done

    task automatic wait_grant(logic lvl);
        int n;
        n = 0;
        while (GRANT_N !== lvl && n < 100) begin
            @(negedge REF_CLK);
            n++;
        end
        if (n >= 100) begin
            miscompares++;
            report_and_stop();
        end
    endtask : wait_grant

    task automatic run(logic [31:0] a, logic wr, int reps, logic slow);
        int t0;
        int t1;
        drive(a, wr, 1'b1);
        wait_done(t0);
        for (int i = 1; i < reps; i++) begin
            wait_done(t1);
            if (slow) begin
                check("stretch", 32'(t1 - t0 > exp_gap(a, wr)), 1);
            end else begin
                check("spacing", 32'(t1 - t0), exp_gap(a, wr));
            end
            t0 = t1;
        end
        if (wr) begin
            check("write data", 32'(last_wdata), 32'(REQ_WDATA));
        end else begin
            check("read data", 32'(RSP_RDATA), a[31:16] ^ a[15:0] ^ 16'h3c5a);
        end
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
    endtask : run

    // ==========================================================
    // clock, cycle count and bus monitor
    initial begin
        REF_CLK = 1'b0;
        forever #5 REF_CLK = ~REF_CLK;
    end

    always @(posedge REF_CLK) cyc <= cyc + 1;

    // a driver left on while the bus is granted would fight the other master
    always @(negedge REF_CLK) begin
        if (RESET === 1'b0 && GRANT_N === 1'b0) begin
            check("bus float", {ADDR_OE, DATA_OE, CTRL_OE}, 0);
        end
        if (RESET === 1'b0 && (RD_N === 1'b0 || WR_N === 1'b0)) begin
            check("selects", 32'(cs_n), 32'(4'hf ^ 4'(5'h1 << exp_slot(REQ_ADDR))));
            check("address", ADDR_OUT, REQ_ADDR);
            check("driving", {ADDR_OE, CTRL_OE}, 2'h3);
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        {RESET, REQ_VALID, REQ_WRITE, REQ_LAST, want} = 5'h10;
        REQ_ADDR = '0;
        REQ_WDATA = '0;
        RANGE_BASE_MASK = '0;
        RECOVERY_CYCLES = '0;
        wait_len = '0;
        seed = 68176;
        miscompares = 0;
        n_tests = 0;
        cyc = 0;
        repeat (5) @(posedge REF_CLK);
        RESET <= 1'b0;
        // random overlapping ranges, recovery counts and mixed traffic
        for (int i = 0; i < 24; i++) begin
            @(posedge REF_CLK);
            for (int r = 0; r < 4; r++) begin
                RANGE_BASE_MASK[r] <= {16'hc000 | 16'(rnd() & 3), 16'(rnd() & 255)};
            end
            RECOVERY_CYCLES <= 10'(rnd());
            @(posedge REF_CLK);
            run({(i % 6 == 5) ? 16'h4000 : 16'hc000 | 16'(rnd() & 3),
                16'(rnd())}, i % 3 == 2, 2, 1'b0);
        end
        // slow memory holds wait low
        wait_len <= 4'h4;
        run(32'h4000_0010, 1'b0, 2, 1'b1);
        wait_len <= 4'h0;
        // two-piece transfer with the master asking mid-way
        drive(32'h4001_0000, 1'b0, 1'b0);
        repeat (2) @(posedge REF_CLK);
        want <= 1'b1;
        wait_done(t);
        drive(32'h4001_0002, 1'b0, 1'b1);
        wait_done(t);
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
        wait_grant(1'b0);
        // own access stalls while the bus is away
        drive(32'hc000_0020, 1'b1, 1'b1);
        repeat (20) begin
            @(negedge REF_CLK);
            check("stalled", 32'(RSP_DONE), 0);
        end
        want <= 1'b0; // master keeps its claim short
        wait_done(t);
        check("grant back", 32'(GRANT_N), 1);
        @(posedge REF_CLK);
        REQ_VALID <= 1'b0;
        repeat (4) @(posedge REF_CLK);
        report_and_stop();
    end
endmodule : tb_ebracd_ext_bus

// [src/ebracd_cs_decode.sv]
`timescale 1ns/1ns

module ebracd_cs_decode (
    // physical address of the cycle about to start
    input wire logic [31:0] addr,
    // programmed ranges
    input wire ebracd_pkg::ebracd_range_type [3:0] ranges,
    // one-hot select, hit flag and index
    output logic [3:0] sel,
    output logic hit,
    output logic [1:0] idx
);
    import ebracd_pkg::*;

    logic [3:0] match;

    // ==========================================================
    // per-range compare on unmasked bits only
    for (genvar i = 0; i < CS_COUNT; i++) begin : g_range
        localparam int SH = (i < LOW_PAIR_LIMIT) ? MASK_SHIFT_LOW
                                                 : MASK_SHIFT_HIGH;
        logic [31:0] cmp;
        logic [31:0] base_full;
        // bits below the lowest maskable bit lie inside the block
        assign cmp = ~({16'h0, ranges[i].mask} << SH)
                     & ~((32'h1 << SH) - 32'h1);
        assign base_full = {ranges[i].base, 16'h0};
        assign match[i] = ((addr ^ base_full) & cmp) == 32'h0;
    end

    // lowest index wins so overlaps never drive two selects
    always_comb begin
        sel = match & (~match + 4'h1);
        hit = |match;
        idx = 2'h0;
        for (int i = CS_COUNT - 1; i >= 0; i--) begin
            if (match[i]) begin
                idx = 2'(i);
            end
        end
    end

endmodule : ebracd_cs_decode

// [src/ebracd_ext_bus.sv]
`timescale 1ns/1ns

module ebracd_ext_bus (
    // clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // internal external-access request, held until done
    input wire logic REQ_VALID,
    input wire logic [31:0] REQ_ADDR,
    input wire logic REQ_WRITE,
    input wire logic REQ_LAST,
    input wire logic [15:0] REQ_WDATA,
    output logic RSP_DONE,
    output logic [15:0] RSP_RDATA,
    // configuration
    input wire ebracd_pkg::ebracd_range_type [3:0] RANGE_BASE_MASK,
    input wire logic [4:0][1:0] RECOVERY_CYCLES,
    // external memory bus
    output logic [31:0] ADDR_OUT,
    output logic ADDR_OE,
    output logic [15:0] DATA_OUT,
    output logic DATA_OE,
    input wire logic [15:0] DATA_IN,
    output logic RD_N,
    output logic WR_N,
    output logic CTRL_OE,
    input wire logic WAIT_N,
    output logic CHIP_SELECT_0_N,
    output logic CHIP_SELECT_1_N,
    output logic CHIP_SELECT_2_N,
    output logic CHIP_SELECT_3_N,
    // arbitration with an outside master
    input wire logic EXT_MASTER_REQUEST_N,
    output logic EXT_MASTER_GRANT_N
);
    import ebracd_pkg::*;

    ebracd_bus_state_type cur;
    ebracd_bus_state_type next_cur;
    logic [1:0] pins;
    logic req_on;
    logic wait_on;
    logic [3:0] sel;
    logic hit;
    logic [1:0] idx;
    logic [2:0] slot;
    logic [1:0] rcv_raw;

    // ==========================================================
    // pin synchronisers for request and wait
    ebracd_pin_sync #(
        .WIDTH(2),
        .IDLE_VALUE(SYNC_IDLE)
    ) u_sync (
        .clk(REF_CLK),
        .reset(RESET),
        .pin({EXT_MASTER_REQUEST_N, WAIT_N}),
        .level(pins)
    );

    assign req_on = ~pins[1];
    assign wait_on = ~pins[0];

    // ==========================================================
    // decode of the address presented by the requester
    ebracd_cs_decode u_decode (
        .addr(REQ_ADDR),
        .ranges(RANGE_BASE_MASK),
        .sel(sel),
        .hit(hit),
        .idx(idx)
    );

    // addresses outside every range use the spare recovery slot
    assign slot = hit ? {1'b0, idx} : RCV_OTHER_SLOT;
    assign rcv_raw = RECOVERY_CYCLES[slot];

    // ==========================================================
    // bus sequencer; only external accesses reach this block, so
    // internal ram, rom and registers stay free while granted
    always_comb begin
        next_cur = cur;
        next_cur.done = 1'b0;
        case (cur.state)
            ST_IDLE: begin
                // an idle bus is a cycle boundary; a cycle started
                // during the dummies runs before any grant
                if (req_on && !cur.mid && !cur.started) begin
                    next_cur.state = ST_GRANT;
                end else if (cur.started || (REQ_VALID && !cur.done)) begin
                    next_cur.state = ST_ADDR;
                end
            end
            ST_ADDR: begin
                next_cur.state = ST_STROBE;
                next_cur.rd_n = cur.write;
                next_cur.wr_n = !cur.write;
                next_cur.data_oe = cur.write;
            end
            ST_STROBE: begin
                // stretch while the memory holds wait low
                if (!wait_on) begin
                    next_cur.state = ST_FINISH;
                    next_cur.rdata = DATA_IN;
                end
            end
            ST_FINISH: begin
                next_cur.rd_n = 1'b1;
                next_cur.wr_n = 1'b1;
                next_cur.data_oe = 1'b0;
                next_cur.cs_n = CS_IDLE_N;
                next_cur.done = 1'b1;
                next_cur.mid = !cur.last;
                next_cur.started = 1'b0;
                // request sampled at the end of the last cycle of a transfer
                if (req_on && cur.last) begin
                    next_cur.state = ST_GRANT;
                end else if (!cur.write && cur.rcv != RCV_NONE) begin
                    next_cur.state = ST_DUMMY;
                    next_cur.dummy_left = cur.rcv;
                end else begin
                    next_cur.state = ST_IDLE;
                end
            end
            ST_DUMMY: begin
                // the done cycle is the usual turnaround, so dummies
                // are counted after it; otherwise they would add nothing
                if (!cur.done) begin
                    // a request seen here has started internally already
                    if (REQ_VALID) begin
                        next_cur.started = 1'b1;
                    end
                    next_cur.dummy_left = cur.dummy_left - 2'h1;
                    if (cur.dummy_left == RCV_LAST) begin
                        next_cur.state = ST_IDLE;
                    end
                end
            end
            ST_GRANT: begin
                // internal requests wait here until the master leaves
                if (!req_on) begin
                    next_cur.state = ST_REDRIVE;
                    next_cur.grant_n = 1'b1;
                end
            end
            ST_REDRIVE: begin
                // own drivers back on before our next cycle
                next_cur.state = ST_IDLE;
                next_cur.addr_oe = 1'b1;
                next_cur.ctrl_oe = 1'b1;
            end
            default: begin
                next_cur.state = ST_IDLE;
            end
        endcase

        // launch of a cycle: decode on every cycle, physical address
        if (next_cur.state == ST_ADDR && cur.state != ST_ADDR) begin
            next_cur.addr = REQ_ADDR;
            next_cur.write = REQ_WRITE;
            next_cur.wdata = REQ_WDATA;
            next_cur.last = REQ_LAST;
            next_cur.cs_n = ~sel;
            next_cur.rcv = (rcv_raw > RCV_MAX) ? RCV_MAX : rcv_raw;
        end

        // grant and floating share one edge
        if (next_cur.state == ST_GRANT && cur.state != ST_GRANT) begin
            next_cur.grant_n = 1'b0;
            next_cur.addr_oe = 1'b0;
            next_cur.data_oe = 1'b0;
            next_cur.ctrl_oe = 1'b0;
            next_cur.cs_n = CS_IDLE_N;
        end
    end

    // register the copy
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            cur <= '{state: ST_IDLE, dummy_left: RCV_NONE,
                     rcv: RCV_NONE, cs_n: CS_IDLE_N, rd_n: 1'b1,
                     wr_n: 1'b1, addr_oe: 1'b1, ctrl_oe: 1'b1,
                     grant_n: 1'b1, default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // ==========================================================
    // outputs, each straight from the state flops
    assign RSP_DONE = cur.done;
    assign RSP_RDATA = cur.rdata;
    assign ADDR_OUT = cur.addr;
    assign ADDR_OE = cur.addr_oe;
    assign DATA_OUT = cur.wdata;
    assign DATA_OE = cur.data_oe;
    assign RD_N = cur.rd_n;
    assign WR_N = cur.wr_n;
    assign CTRL_OE = cur.ctrl_oe;
    assign CHIP_SELECT_0_N = cur.cs_n[0];
    assign CHIP_SELECT_1_N = cur.cs_n[1];
    assign CHIP_SELECT_2_N = cur.cs_n[2];
    assign CHIP_SELECT_3_N = cur.cs_n[3];
    assign EXT_MASTER_GRANT_N = cur.grant_n;

    // ==========================================================
    // checks
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    // the first dummy state cycle carries the done pulse
    property p_one_dummy;
        cur.state == ST_FINISH && !cur.write && cur.rcv == RCV_LAST
            && !(req_on && cur.last)
        |=> (cur.state == ST_DUMMY) [*2] ##1 cur.state == ST_IDLE;
    endproperty
    a_one_dummy: assert property (p_one_dummy)
        else $error("one recovery cycle expected after read");

    property p_no_dummy_write;
        cur.state == ST_FINISH && cur.write |=> cur.state != ST_DUMMY;
    endproperty
    a_no_dummy_write: assert property (p_no_dummy_write)
        else $error("dummy cycle after a write");

    property p_two_dummy;
        cur.state == ST_FINISH && !cur.write && cur.rcv == RCV_MAX
            && !(req_on && cur.last)
        |=> (cur.state == ST_DUMMY) [*3] ##1 cur.state == ST_IDLE;
    endproperty
    a_two_dummy: assert property (p_two_dummy)
        else $error("two recovery cycles expected after read");

    property p_float_with_grant;
        $fell(cur.grant_n) |-> !cur.addr_oe && !cur.data_oe
            && !cur.ctrl_oe && cur.cs_n == CS_IDLE_N;
    endproperty
    a_float_with_grant: assert property (p_float_with_grant)
        else $error("bus still driven when grant asserted");

    property p_grant_boundary;
        $rose(cur.state == ST_GRANT) |-> $past(cur.state) inside
            {ST_IDLE, ST_FINISH, ST_DUMMY};
    endproperty
    a_grant_boundary: assert property (p_grant_boundary)
        else $error("grant taken inside a bus cycle");

    property p_no_grant_mid;
        cur.state == ST_FINISH && !cur.last
        |=> cur.state != ST_GRANT ##1 cur.state != ST_GRANT;
    endproperty
    a_no_grant_mid: assert property (p_no_grant_mid)
        else $error("grant inside a sized transfer");

    property p_dummy_started;
        cur.state == ST_DUMMY && !cur.done && cur.dummy_left == RCV_LAST
            && (cur.started || REQ_VALID)
        |=> cur.state == ST_IDLE ##1 cur.state == ST_ADDR;
    endproperty
    a_dummy_started: assert property (p_dummy_started)
        else $error("started cycle not run after dummy");

    property p_release;
        cur.state == ST_GRANT && !req_on
        |=> cur.grant_n && !cur.ctrl_oe ##1 cur.ctrl_oe && cur.addr_oe;
    endproperty
    a_release: assert property (p_release)
        else $error("grant or redrive wrong on release");

    property p_stall;
        cur.state == ST_GRANT |=> !cur.done
            && cur.state inside {ST_GRANT, ST_REDRIVE};
    endproperty
    a_stall: assert property (p_stall)
        else $error("own cycle started while granted");

    property p_wait;
        cur.state == ST_STROBE && wait_on |=> cur.state == ST_STROBE;
    endproperty
    a_wait: assert property (p_wait)
        else $error("cycle not stretched by wait");

    property p_single_select;
        $onehot0(~cur.cs_n);
    endproperty
    a_single_select: assert property (p_single_select)
        else $error("more than one chip select low");

    c_grant: cover property ($fell(cur.grant_n));
    c_two_dummy: cover property ((cur.state == ST_DUMMY) [*3]);
    c_wait: cover property ((cur.state == ST_STROBE) [*3]);

endmodule : ebracd_ext_bus

// [src/ebracd_pin_sync.sv]
`timescale 1ns/1ns

module ebracd_pin_sync #(
    parameter int WIDTH = 2,
    parameter logic [WIDTH-1:0] IDLE_VALUE = '1
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pins and their filtered level
    input wire logic [WIDTH-1:0] pin,
    output logic [WIDTH-1:0] level
);

    // ==========================================================
    // three stages; the first feeds only the second
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } ebracd_sync_type;

    ebracd_sync_type cur;
    ebracd_sync_type next_cur;

    // a change counts only once stages two and three agree
    always_comb begin
        next_cur = cur;
        next_cur.s1 = pin;
        next_cur.s2 = cur.s1;
        next_cur.s3 = cur.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (cur.s2[i] == cur.s3[i]) begin
                next_cur.level[i] = cur.s3[i];
            end
        end
    end

    // register the copy
    always_ff @(posedge clk) begin
        if (reset) begin
            cur <= {IDLE_VALUE, IDLE_VALUE, IDLE_VALUE, IDLE_VALUE};
        end else begin
            cur <= next_cur;
        end
    end

    assign level = cur.level;

endmodule : ebracd_pin_sync

// [src/ebracd_pkg.sv]
package ebracd_pkg;

    // ==========================================================
    // sizes and field positions
    localparam int CS_COUNT = 4;
    localparam int RCV_SLOTS = 5;
    localparam logic [2:0] RCV_OTHER_SLOT = 3'h4;
    localparam int BASE_SHIFT = 16;
    localparam int MASK_SHIFT_LOW = 14;
    localparam int MASK_SHIFT_HIGH = 15;
    localparam int LOW_PAIR_LIMIT = 2;
    localparam logic [1:0] RCV_MAX = 2'h2;
    localparam logic [1:0] RCV_NONE = 2'h0;
    localparam logic [1:0] RCV_LAST = 2'h1;

    // ==========================================================
    // reset values
    localparam logic [3:0] CS_IDLE_N = 4'hf;
    localparam logic [1:0] SYNC_IDLE = 2'h3;

    // ==========================================================
    // bus cycle sequencer, gray along idle-addr-strobe-finish-dummy
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_STROBE = 3'h3,
        ST_FINISH = 3'h2,
        ST_DUMMY = 3'h6,
        ST_GRANT = 3'h7,
        ST_REDRIVE = 3'h5
    } ebracd_state_type;

    // one chip-select range: base gives a31..a16, mask picks block size
    typedef struct packed {
        logic [15:0] base;
        logic [15:0] mask;
    } ebracd_range_type;

    // whole state of the bus sequencer
    typedef struct packed {
        ebracd_state_type state;
        logic [1:0] dummy_left;
        logic started;
        logic mid;
        logic last;
        logic write;
        logic [31:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [3:0] cs_n;
        logic [1:0] rcv;
        logic rd_n;
        logic wr_n;
        logic addr_oe;
        logic data_oe;
        logic ctrl_oe;
        logic grant_n;
        logic done;
    } ebracd_bus_state_type;

endpackage : ebracd_pkg
